/* design/rtcip_pkg.sv */
package rtcip_pkg;

   // Bus timing and register indices; byte address is four times the index
   localparam int RTCIP_CLK_PERIOD_NS = 8;
   localparam logic [5:0] RTCIP_IDX_ADDR_CTRL = 6'h0B;
   localparam logic [5:0] RTCIP_IDX_DATA = 6'h0C;
   localparam logic [5:0] RTCIP_IDX_KEY = 6'h0D;
   localparam logic [5:0] RTCIP_IDX_LOCK_STATUS = 6'h0E;

   // Field positions of the address/control register
   localparam int RTCIP_CTRL_BUSY = 7;
   localparam int RTCIP_CTRL_AUTOREAD_ENABLE = 6;
   localparam int RTCIP_CTRL_SHORT = 4;
   localparam logic [7:0] RTCIP_DATA_RESET = 8'h00;

   // Internal indirect register map
   localparam logic [3:0] RTCIP_IR_SNAP_FIRST = 4'h0;
   localparam logic [3:0] RTCIP_IR_SNAP_LAST = 4'h3;
   localparam logic [3:0] RTCIP_IR_CLOCK_CTRL = 4'h4;
   localparam logic [3:0] RTCIP_IR_OSC_CTRL = 4'h5;
   localparam logic [3:0] RTCIP_IR_OSC_CONFIG = 4'h6;
   localparam logic [3:0] RTCIP_IR_ALARM_FIRST = 4'h8;
   localparam logic [3:0] RTCIP_IR_ALARM_LAST = 4'hB;

   // Bit positions inside the internal registers
   localparam int RTCIP_CC_POWER = 7;
   localparam int RTCIP_CC_MISS_EN = 6;
   localparam int RTCIP_CC_FAIL = 5;
   localparam int RTCIP_OC_XTAL = 7;
   localparam int RTCIP_OC_GAIN = 6;
   localparam int RTCIP_OC_BIAS2 = 5;
   localparam int RTCIP_OC_CLOCK_VALID_FLAG = 4;
   localparam int RTCIP_CF_AUTOSTEP = 7;
   localparam int RTCIP_CF_READY = 6;

   // Transfer lengths in bus clocks for short and long strobes
   localparam logic [2:0] RTCIP_XFER_SHORT = 3'h2;
   localparam logic [2:0] RTCIP_XFER_LONG = 3'h6;

   // Missing clock limit and load capacitance step interval
   localparam int RTCIP_MISS_TIME_NS = 100000;
   localparam int RTCIP_MISS_CYCLES = RTCIP_MISS_TIME_NS / RTCIP_CLK_PERIOD_NS;
   localparam int RTCIP_STEP_TIME_NS = 1000;
   localparam int RTCIP_STEP_CYCLES = RTCIP_STEP_TIME_NS / RTCIP_CLK_PERIOD_NS;

   // Interface lock states and unlock keys (key values are arbitrary)
   localparam logic [1:0] RTCIP_LOCKED = 2'h0;
   localparam logic [1:0] RTCIP_HALF_KEY = 2'h1;
   localparam logic [1:0] RTCIP_UNLOCKED = 2'h2;
   localparam logic [7:0] RTCIP_KEY_FIRST = 8'hA5;
   localparam logic [7:0] RTCIP_KEY_SECOND = 8'hF1;

   localparam logic [1:0] RTCIP_RESP_OKAY = 2'h0;
   localparam logic [1:0] RTCIP_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      RTCIP_IDLE = 3'b001,
      RTCIP_RD = 3'b010,
      RTCIP_WR = 3'b100
   } rtcip_state_t;

   // Load capacitance in tenths of a pF for a 4-bit code
   function automatic logic [7:0] rtcip_cap_tenths(input logic [3:0] code);
      logic [7:0] c;
      c = {4'h0, code};
      if (code < 4'hC) begin
         rtcip_cap_tenths = 8'h28 + 8'(c * 8'h05);
      end else begin
         rtcip_cap_tenths = 8'h5F + 8'((c - 8'h0B) * 8'h0A);
      end
   endfunction

endpackage

/* design/rtcip_cap_stepper.sv */
`timescale 1ns/1ps
module rtcip_cap_stepper
   import rtcip_pkg::*;
#(
   parameter int STEP_CYCLES = RTCIP_STEP_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic osc_on,
   input wire logic auto_step,
   input wire logic [3:0] target,
   output logic [3:0] cap_code,
   output logic load_ready
);
   localparam int TW = $clog2(STEP_CYCLES + 1);

   logic [TW-1:0] tick;
   logic [3:0] next_cap;
   logic [TW-1:0] next_tick;
   wire step_due = (tick == TW'(STEP_CYCLES - 1));
   wire stepping = osc_on && auto_step && (cap_code < target);

   // Start from the smallest setting so the crystal starts quickly
   always_comb begin
      next_cap = cap_code;
      next_tick = '0;
      if (!osc_on && auto_step) begin
         next_cap = 4'h0;
      end else if (!auto_step || cap_code > target) begin
         next_cap = target;
      end else if (stepping) begin
         next_tick = step_due ? '0 : tick + TW'(1);
         if (step_due) begin
            next_cap = cap_code + 4'h1;
         end
      end
   end

   // Ready only once the final setting is in place
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_code <= 4'h0;
         tick <= '0;
         load_ready <= 1'b0;
      end else begin
         cap_code <= next_cap;
         tick <= next_tick;
         load_ready <= osc_on && (next_cap == target);
      end
   end
endmodule

/* design/rtcip_top.sv */
`timescale 1ns/1ps
// Contract
// - Bit 7 shows busy; writing 1 starts read
// - Bit 6 enables autoread
// - Bit 5 reads zero, writes ignored
// - Bit 4 enables short strobe
// - Bits 3:0 select internal register
// - Snapshot and alarm accesses auto-increment address
// - Data register holds transferred byte, resets zero
// - Clock core runs on own oscillator timebase
// - Self-oscillate rate set by bias double
// - Sixteen load capacitance settings, four-bit field
// - Auto stepping climbs from smallest to target
// - Load-ready flag sets at final value
// - Code maps 4.0 pF up to 13.5 pF
// - Oscillator control bit 5 enables bias doubling
// - Missing clock detector sets failure flag
// - Detector timeout raises wake and interrupt event; here only a one-cycle osc_fail_event pulse, no wake output
// - Key write while unlocked relocks interface
module rtcip_top
   import rtcip_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int MISS_CYCLES = RTCIP_MISS_CYCLES,
   parameter int STEP_CYCLES = RTCIP_STEP_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic osc_clk_in,
   input wire logic clock_valid_in,
   output logic osc_power_enable,
   output logic crystal_mode_select,
   output logic gain_control_enable,
   output logic bias_double,
   output logic [3:0] load_cap_code,
   output logic [7:0] load_cap_tenth_pf,
   output logic osc_fail_event
);
   localparam int MW = $clog2(MISS_CYCLES + 1);

   // Write channel holding registers
   logic aw_full, w_full;
   logic [ADDR_W-1:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   // Indirect port state
   logic autoread_enable, short_strobe;
   logic [3:0] ind_addr;
   logic [7:0] ind_data;
   logic [1:0] lock_state;
   rtcip_state_t state;
   logic [2:0] cnt;
   logic [7:0] mem [16];
   logic osc_fail, osc_prev;
   logic [MW-1:0] miss_cnt;
   logic load_ready;

   // Write request decode; an address or data beat may wait for its partner
   wire aw_hs = awvalid && awready;
   wire w_hs = wvalid && wready;
   wire do_wr = (aw_full || aw_hs) && (w_full || w_hs);
   wire [ADDR_W-1:0] wr_addr = aw_full ? aw_q : awaddr;
   wire [31:0] wr_data = w_full ? w_q : wdata;
   wire [3:0] wr_strb = w_full ? ws_q : wstrb;
   wire [5:0] wr_idx = wr_addr[7:2];
   wire wr_lane = wr_strb[0];
   wire [7:0] wr_byte = wr_data[7:0];
   wire wr_known = (wr_idx == RTCIP_IDX_ADDR_CTRL) ||
      (wr_idx == RTCIP_IDX_DATA) || (wr_idx == RTCIP_IDX_KEY) ||
      (wr_idx == RTCIP_IDX_LOCK_STATUS);
   assign awready = !aw_full && !bvalid;
   assign wready = !w_full && !bvalid;

   // Indirect side effects; refused while busy or locked
   wire busy = (state != RTCIP_IDLE);
   wire unlocked = (lock_state == RTCIP_UNLOCKED);
   wire port_free = !busy && unlocked;
   wire ctrl_wr = do_wr && wr_lane && port_free &&
      (wr_idx == RTCIP_IDX_ADDR_CTRL);
   wire data_wr = do_wr && wr_lane && port_free && (wr_idx == RTCIP_IDX_DATA);
   wire key_wr = do_wr && wr_lane && (wr_idx == RTCIP_IDX_KEY);

   // Read request decode
   wire ar_hs = arvalid && arready;
   wire [5:0] rd_idx = araddr[7:2];
   wire autoread_go = ar_hs && (rd_idx == RTCIP_IDX_DATA) && autoread_enable
      && port_free;
   wire start_rd = (ctrl_wr && wr_byte[RTCIP_CTRL_BUSY]) || autoread_go;
   wire start_wr = data_wr;
   assign arready = !rvalid;

   // Internal register views with hardware-owned bits overlaid
   wire [7:0] cc_view = {mem[RTCIP_IR_CLOCK_CTRL][7:6], osc_fail,
      mem[RTCIP_IR_CLOCK_CTRL][4:0]};
   wire [7:0] oc_view = {mem[RTCIP_IR_OSC_CTRL][7:5], clock_valid_in,
      mem[RTCIP_IR_OSC_CTRL][3:0]};
   wire [7:0] cf_view = {mem[RTCIP_IR_OSC_CONFIG][RTCIP_CF_AUTOSTEP],
      load_ready, 2'b00, mem[RTCIP_IR_OSC_CONFIG][3:0]};
   wire [7:0] ind_view = (ind_addr == RTCIP_IR_CLOCK_CTRL) ? cc_view :
      (ind_addr == RTCIP_IR_OSC_CTRL) ? oc_view :
      (ind_addr == RTCIP_IR_OSC_CONFIG) ? cf_view : mem[ind_addr];

   // Register read mux; bit 5 of the control register is always zero
   wire [7:0] ctrl_view = {busy, autoread_enable, 1'b0, short_strobe,
      ind_addr};
   wire rd_known = (rd_idx == RTCIP_IDX_ADDR_CTRL) ||
      (rd_idx == RTCIP_IDX_DATA) || (rd_idx == RTCIP_IDX_KEY) ||
      (rd_idx == RTCIP_IDX_LOCK_STATUS);
   wire [7:0] rd_byte = (rd_idx == RTCIP_IDX_ADDR_CTRL) ? ctrl_view :
      (rd_idx == RTCIP_IDX_DATA) ? ind_data :
      (rd_idx == RTCIP_IDX_LOCK_STATUS) ? {6'h00, lock_state} : 8'h00;

   // Transfer completion and address stepping for block targets
   wire xfer_done = busy && (cnt == 3'h0);
   wire block_tgt = (ind_addr <= RTCIP_IR_SNAP_LAST) ||
      ((ind_addr >= RTCIP_IR_ALARM_FIRST) &&
      (ind_addr <= RTCIP_IR_ALARM_LAST));
   wire mem_we = (state == RTCIP_WR) && (cnt == 3'h0);
   wire [2:0] xfer_len = short_strobe ? RTCIP_XFER_SHORT : RTCIP_XFER_LONG;

   // Missing clock detector: a stuck level for too long is a failure
   wire miss_en = mem[RTCIP_IR_CLOCK_CTRL][RTCIP_CC_MISS_EN];
   wire osc_same = (osc_clk_in == osc_prev);
   wire miss_hit = miss_en && osc_same &&
      (miss_cnt == MW'(MISS_CYCLES - 1));
   wire fail_clr = mem_we && (ind_addr == RTCIP_IR_CLOCK_CTRL) &&
      !ind_data[RTCIP_CC_FAIL];

   // Oscillator outputs straight from the stored configuration; load capacitance value from the stepper code
   assign osc_power_enable = mem[RTCIP_IR_CLOCK_CTRL][RTCIP_CC_POWER];
   assign crystal_mode_select = mem[RTCIP_IR_OSC_CTRL][RTCIP_OC_XTAL];
   assign gain_control_enable = mem[RTCIP_IR_OSC_CTRL][RTCIP_OC_GAIN];
   assign bias_double = mem[RTCIP_IR_OSC_CTRL][RTCIP_OC_BIAS2];
   assign load_cap_tenth_pf = rtcip_cap_tenths(load_cap_code);

   // AXI write side: hold whichever beat arrives first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_q <= '0;
         w_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RTCIP_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            aw_q <= awaddr;
         end
         if (w_hs) begin
            w_q <= wdata;
            ws_q <= wstrb;
         end
         aw_full <= (aw_full || aw_hs) && !do_wr;
         w_full <= (w_full || w_hs) && !do_wr;
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? RTCIP_RESP_OKAY : RTCIP_RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // AXI read side: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RTCIP_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_byte};
         rresp <= rd_known ? RTCIP_RESP_OKAY : RTCIP_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Lock sequencer: two keys unlock, any key write while unlocked relocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_state <= RTCIP_LOCKED;
      end else if (key_wr) begin
         case (lock_state)
            RTCIP_LOCKED: begin
               lock_state <= (wr_byte == RTCIP_KEY_FIRST) ?
                  RTCIP_HALF_KEY : RTCIP_LOCKED;
            end
            RTCIP_HALF_KEY: begin
               lock_state <= (wr_byte == RTCIP_KEY_SECOND) ?
                  RTCIP_UNLOCKED : RTCIP_LOCKED;
            end
            default: begin
               lock_state <= RTCIP_LOCKED;
            end
         endcase
      end
   end

   // Indirect engine; strobe length trades speed for slow internal timing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= RTCIP_IDLE;
         cnt <= 3'h0;
         autoread_enable <= 1'b0;
         short_strobe <= 1'b0;
         ind_addr <= 4'h0;
         ind_data <= RTCIP_DATA_RESET;
      end else begin
         case (state)
            RTCIP_IDLE: begin
               if (ctrl_wr) begin
                  autoread_enable <= wr_byte[RTCIP_CTRL_AUTOREAD_ENABLE];
                  short_strobe <= wr_byte[RTCIP_CTRL_SHORT];
                  ind_addr <= wr_byte[3:0];
               end
               if (data_wr) begin
                  ind_data <= wr_byte;
               end
               if (start_rd) begin
                  state <= RTCIP_RD;
                  cnt <= (ctrl_wr && wr_byte[RTCIP_CTRL_SHORT]) ||
                     (!ctrl_wr && short_strobe) ? RTCIP_XFER_SHORT - 3'h1 :
                     RTCIP_XFER_LONG - 3'h1;
               end else if (start_wr) begin
                  state <= RTCIP_WR;
                  cnt <= xfer_len - 3'h1;
               end
            end
            RTCIP_RD, RTCIP_WR: begin
               if (cnt != 3'h0) begin
                  cnt <= cnt - 3'h1;
               end else begin
                  state <= RTCIP_IDLE;
                  if (state == RTCIP_RD) begin
                     ind_data <= ind_view;
                  end
                  if (block_tgt) begin
                     ind_addr <= ind_addr + 4'h1;
                  end
               end
            end
            default: begin
               state <= RTCIP_IDLE;
            end
         endcase
      end
   end

   // Internal register storage, one entry per index
   for (genvar i = 0; i < 16; i++) begin : g_mem
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            mem[i] <= 8'h00;
         end else if (mem_we && (ind_addr == 4'(i))) begin
            mem[i] <= ind_data;
         end
      end
   end

   // Detector counter and failure flag; a new failure beats a clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_prev <= 1'b0;
         miss_cnt <= '0;
         osc_fail <= 1'b0;
         osc_fail_event <= 1'b0;
      end else begin
         osc_prev <= osc_clk_in;
         if (!miss_en || !osc_same) begin
            miss_cnt <= '0;
         end else if (miss_cnt != MW'(MISS_CYCLES)) begin
            miss_cnt <= miss_cnt + MW'(1);
         end
         if (miss_hit) begin
            osc_fail <= 1'b1;
         end else if (fail_clr) begin
            osc_fail <= 1'b0;
         end
         osc_fail_event <= miss_hit;
      end
   end

   // Load capacitance stepping runs beside the register file
   rtcip_cap_stepper #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_stepper (
      .aclk(aclk),
      .aresetn(aresetn),
      .osc_on(osc_power_enable),
      .auto_step(mem[RTCIP_IR_OSC_CONFIG][RTCIP_CF_AUTOSTEP]),
      .target(mem[RTCIP_IR_OSC_CONFIG][3:0]),
      .cap_code(load_cap_code),
      .load_ready(load_ready)
   );

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic rd_ctrl_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ctrl_q <= 1'b0;
      end else if (ar_hs) begin
         rd_ctrl_q <= (rd_idx == RTCIP_IDX_ADDR_CTRL);
      end
   end

   chk_read_starts_busy: assert property (
      start_rd |=> busy && state == RTCIP_RD)
      else $error("indirect read did not start");
   chk_autoread_start: assert property (
      autoread_go |=> state == RTCIP_RD)
      else $error("autoread did not start a read");
   chk_unused_bit_zero: assert property (
      rvalid && rd_ctrl_q |-> rdata[5] == 1'b0)
      else $error("unused control bit read nonzero");
   chk_short_strobe_len: assert property (
      $rose(busy) && short_strobe |-> busy [*2] ##1 !busy)
      else $error("short transfer length wrong");
   chk_long_strobe_len: assert property (
      $rose(busy) && !short_strobe |-> busy [*6] ##1 !busy)
      else $error("long transfer length wrong");
   chk_addr_step: assert property (
      xfer_done && block_tgt |=> ind_addr == $past(ind_addr) + 4'h1)
      else $error("block address did not increment");
   chk_data_capture: assert property (
      xfer_done && state == RTCIP_RD |=> ind_data == $past(ind_view))
      else $error("read data not captured");
   chk_step_up: assert property (
      $changed(load_cap_code) && $past(osc_power_enable) &&
      $past(mem[RTCIP_IR_OSC_CONFIG]) == mem[RTCIP_IR_OSC_CONFIG] &&
      mem[RTCIP_IR_OSC_CONFIG][RTCIP_CF_AUTOSTEP]
      |-> load_cap_code == $past(load_cap_code) + 4'h1)
      else $error("capacitance did not step by one");
   chk_ready_at_target: assert property (
      load_ready |-> load_cap_code == $past(mem[RTCIP_IR_OSC_CONFIG][3:0]))
      else $error("ready flag away from target");
   chk_fail_flag_set: assert property (
      miss_hit |=> osc_fail && osc_fail_event ##1 !osc_fail_event)
      else $error("failure flag or event missing");
   chk_key_relock: assert property (
      key_wr && unlocked |=> lock_state == RTCIP_LOCKED)
      else $error("key write did not relock");
   chk_write_completes: assert property (
      start_wr |=> busy ##[1:6] !busy)
      else $error("indirect write did not complete");

   cov_indirect_read: cover property (start_rd ##[1:8] !busy);
   cov_indirect_write: cover property (start_wr ##[1:8] !busy);
   cov_unlock: cover property ($rose(unlocked));
   cov_osc_fail: cover property ($rose(osc_fail));
endmodule

/* dv/rtcip_osc_model.sv */
`timescale 1ns/1ps
module rtcip_osc_model #(
   parameter int HALF = 3,
   parameter int VALID_DELAY = 10
) (
   input wire logic aclk,
   input wire logic power,
   input wire logic stall,
   output logic osc_clk,
   output logic clk_valid
);
   int div = 0;
   int on_cnt = 0;
   initial begin
      osc_clk = 1'b0;
      clk_valid = 1'b0;
   end
   // Runs only while powered; stall models a dead crystal, line stands still
   always @(posedge aclk) begin
      if (power && !stall) begin
         div <= (div == HALF - 1) ? 0 : div + 1;
         osc_clk <= (div == HALF - 1) ? !osc_clk : osc_clk;
      end
   end
   // Amplitude detector settles a while after power, like a real crystal
   always @(posedge aclk) begin
      on_cnt <= power ? ((on_cnt < VALID_DELAY) ? on_cnt + 1 : on_cnt) : 0;
      clk_valid <= power && (on_cnt >= VALID_DELAY);
   end
endmodule

/* dv/test_rtcip_top.sv */
`timescale 1ns/1ps
module test_rtcip_top import rtcip_pkg::*;;
   localparam logic [5:0] CTRL = RTCIP_IDX_ADDR_CTRL;
   localparam logic [5:0] DATA = RTCIP_IDX_DATA;
   localparam logic [5:0] KEY = RTCIP_IDX_KEY;
   localparam logic [5:0] STAT = RTCIP_IDX_LOCK_STATUS;
   localparam logic [1:0] OK = RTCIP_RESP_OKAY;
   localparam logic [1:0] ERR = RTCIP_RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, stall = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, osc_fail_event;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic osc_clk_in, clock_valid_in, osc_power_enable, crystal_mode_select;
   logic gain_control_enable, bias_double;
   wire [2:0] osc_bits =
      {crystal_mode_select, gain_control_enable, bias_double};
   logic [3:0] load_cap_code, prev_code;
   logic [7:0] load_cap_tenth_pf;
   logic step_watch = 1'b0;
   int failures = 0, n_compared = 0, bad_steps = 0, fail_pulses = 0, i, n;

   always #(RTCIP_CLK_PERIOD_NS / 2) aclk = ~aclk;

   rtcip_top #(.MISS_CYCLES(20), .STEP_CYCLES(4)) rtcip_top_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .osc_clk_in(osc_clk_in), .clock_valid_in(clock_valid_in),
      .osc_power_enable(osc_power_enable),
      .crystal_mode_select(crystal_mode_select),
      .gain_control_enable(gain_control_enable), .bias_double(bias_double),
      .load_cap_code(load_cap_code), .load_cap_tenth_pf(load_cap_tenth_pf),
      .osc_fail_event(osc_fail_event));

   rtcip_osc_model rtcip_osc_model_i (.aclk(aclk), .power(osc_power_enable),
      .stall(stall), .osc_clk(osc_clk_in), .clk_valid(clock_valid_in));

   // Stepping must climb by one code; fail events are counted as pulses
   always @(posedge aclk) begin
      prev_code <= load_cap_code;
      if (step_watch && load_cap_code !== prev_code &&
          load_cap_code !== prev_code + 4'h1) begin
         bad_steps <= bad_steps + 1;
      end
      if (osc_fail_event === 1'b1) begin
         fail_pulses <= fail_pulses + 1;
      end
   end

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic timeout_if(input logic done);
      if (done !== 1'b1) begin
         failures++;
         $display("Error at %0t: wait ran out, seen %h expected %h", $time,
            1'b0, 1'b1);
         summarize();
      end
   endtask

   // Master releases each channel only at the edge where it was taken
   task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_hs = 1'b0;
      for (int k = 0; k < 50 && !b_hs; k++) begin
         @(negedge aclk);
         aw_hs = awvalid && awready;
         w_hs = wvalid && wready;
         b_hs = bvalid;
         r = bresp;
         @(posedge aclk);
         awvalid <= awvalid && !aw_hs;
         wvalid <= wvalid && !w_hs;
         bready <= !b_hs;
      end
      timeout_if(b_hs);
      check({30'h0000_0000, r}, {30'h0000_0000, er});
   endtask

   task automatic rd(input logic [5:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
      logic ar_hs, r_hs;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_hs = 1'b0;
      for (int k = 0; k < 50 && !r_hs; k++) begin
         @(negedge aclk);
         ar_hs = arvalid && arready;
         r_hs = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         arvalid <= arvalid && !ar_hs;
         rready <= !r_hs;
      end
      timeout_if(r_hs);
   endtask

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e,
                         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      check(d, {24'h00_0000, e});
      check({30'h0000_0000, r}, {30'h0000_0000, er});
   endtask

   // Writes to the port are dropped while busy, so always poll it clear
   task automatic wait_idle();
      logic [31:0] d;
      logic [1:0] r;
      d = 32'h0000_0080;
      for (int k = 0; k < 20 && d[7] !== 1'b0; k++) begin
         rd(CTRL, d, r);
      end
      timeout_if(d[7] === 1'b0);
   endtask

   task automatic iwr(input logic [3:0] a, input logic [7:0] d);
      wr(CTRL, {4'h1, a}, OK);
      wr(DATA, d, OK);
      wait_idle();
   endtask

   task automatic ird_chk(input logic [3:0] a, input logic [7:0] e);
      wr(CTRL, {4'h9, a}, OK);
      wait_idle();
      rd_chk(DATA, e, OK);
   endtask

   task automatic unlock();
      wr(KEY, RTCIP_KEY_FIRST, OK);
      wr(KEY, RTCIP_KEY_SECOND, OK);
   endtask

   function automatic logic [7:0] exp_tenths(input int c);
      return (c < 12) ? 8'(40 + 5 * c) : 8'(105 + 10 * (c - 12));
   endfunction

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(DATA, 8'h00, OK);
      rd_chk(CTRL, 8'h00, OK);
      rd_chk(6'h3F, 8'h00, ERR);
      wr(6'h3F, 8'h5A, ERR);
      $display("test reset done");
      // Locked port must ignore control writes
      wr(CTRL, 8'h13, OK);
      rd_chk(CTRL, 8'h00, OK);
      unlock();
      rd_chk(STAT, {6'h00, RTCIP_UNLOCKED}, OK);
      wr(KEY, 8'h00, OK);
      rd_chk(STAT, {6'h00, RTCIP_LOCKED}, OK);
      unlock();
      // Lane 0 disabled: the write must leave the port untouched
      wstrb <= 4'h0;
      wr(CTRL, 8'h13, OK);
      wstrb <= 4'hF;
      rd_chk(CTRL, 8'h00, OK);
      $display("test lock done");
      // Unused bit reads zero, the other fields hold what was written
      wr(CTRL, 8'h75, OK);
      rd_chk(CTRL, 8'h55, OK);
      wr(CTRL, 8'h10, OK);
      for (i = 0; i < 4; i++) begin
         wr(DATA, 8'(8'h10 + i), OK);
         wait_idle();
      end
      rd_chk(CTRL, 8'h14, OK);
      wr(CTRL, 8'h80, OK);
      rd_chk(CTRL, 8'h80, OK);
      wait_idle();
      rd_chk(DATA, 8'h10, OK);
      rd_chk(CTRL, 8'h01, OK);
      wr(CTRL, 8'hD1, OK);
      wait_idle();
      rd_chk(DATA, 8'h11, OK);
      wait_idle();
      rd_chk(DATA, 8'h12, OK);
      wait_idle();
      wr(CTRL, 8'h10, OK);
      $display("test transfer done");
      // Oscillator settings first; the detector stays off meanwhile
      iwr(4'h5, 8'hE0);
      check({29'h0000_0000, osc_bits}, 32'h0000_0007);
      rd_chk(CTRL, 8'h15, OK);
      wr(CTRL, 8'h16, OK);
      for (i = 0; i < 16; i++) begin
         wr(DATA, 8'(i), OK);
         wait_idle();
         check({24'h00_0000, load_cap_tenth_pf}, 32'(exp_tenths(i)));
         check({28'h000_0000, load_cap_code}, 32'(i));
      end
      $display("test osc done");
      // Auto stepping restarts at the smallest code and climbs to target
      wr(DATA, 8'h8F, OK);
      wait_idle();
      check({28'h000_0000, load_cap_code}, 32'h0000_0000);
      step_watch = 1'b1;
      iwr(4'h4, 8'h80);
      for (n = 0; n < 200 && load_cap_code !== 4'hF; n++) @(posedge aclk);
      timeout_if(load_cap_code === 4'hF);
      check(32'(bad_steps), 32'h0000_0000);
      ird_chk(4'h6, 8'hCF);
      ird_chk(4'h5, 8'hF0);
      $display("test stepping done");
      // Detector quiet while the oscillator runs, one event when it stops
      iwr(4'h4, 8'hC0);
      repeat (40) @(posedge aclk);
      ird_chk(4'h4, 8'hC0);
      stall <= 1'b1;
      for (n = 0; n < 80 && fail_pulses == 0; n++) @(posedge aclk);
      timeout_if(fail_pulses != 0);
      repeat (40) @(posedge aclk);
      check(32'(fail_pulses), 32'h0000_0001);
      ird_chk(4'h4, 8'hE0);
      $display("test detector done");
      summarize();
   end
endmodule
